// ==== pkg/srs_params.svh ====
// Purpose: Constants of the system reset source block.
// Assumes: CPU clock of 125 MHz, 2 MHz oscillator sampled as a level.
// Notes: Times are given in their own units; cycle counts derive from them.
//
// Notes on behaviour
// [R01] Brownout compares supply to fuse-chosen threshold and resets when below while active.
// [R02] Disabled brownout is forced on at lowest threshold during erase or debug enable.
// [R03] After reset pin stays low beyond minimum pulse, reset holds while pin low.
// [R04] Watchdog resets if software does not restart it before timeout expires.
// [R05] Watchdog reset lasts one to two 2 MHz oscillator periods.
// [R06] Writing the software reset bit starts a full system reset.
// [R07] Software reset asserts within two CPU clock cycles of the write.
// [R08] No instruction runs between software reset request and reset assertion.
// [R09] Debug reset source is driven only by the external debug interface.
// [R10] Combined reset holds while any source is active, releases synchronously.
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH

`define SRS_CLK_MHZ 125
`define SRS_TEXT_NS 1000
`define SRS_TEXT_CYC ((`SRS_TEXT_NS * `SRS_CLK_MHZ + 999) / 1000)
`define SRS_TEXT_W 8
`define SRS_SW_HOLD_CYC 4
`define SRS_BOD_LOWEST 3'h0
`define SRS_BOD_LEVELS 8
`define SRS_WDT_BASE 16'h0008
`define SRS_WDT_SEL_MAX 4'hB

`endif

// ==== pkg/srs_pkg.sv ====
// Purpose: Types of the system reset source block.
// Assumes: Nothing beyond the constants header.
// Notes: One bit per reset source.
package srs_pkg;

    typedef struct packed {
        logic brownout;
        logic ext_pin;
        logic watchdog;
        logic software;
        logic debug;
    } srs_src_s;

    typedef enum logic [1:0] {
        EXT_IDLE = 2'b00,
        EXT_QUAL = 2'b01,
        EXT_HOLD = 2'b10
    } srs_ext_e;

endpackage

// ==== logic/srs_wdt.sv ====
// Purpose: Watchdog timeout counter and reset pulse.
// Assumes: osc_tick is one clk cycle per rising edge of the 2 MHz oscillator.
// Notes: Timeout is the base count shifted by the period select, clamped to SRS_WDT_SEL_MAX.
`timescale 1ns/100ps
`default_nettype none
`include "srs_params.svh"

module srs_wdt (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Oscillator tick
    input wire logic osc_tick,
    // Software control
    input wire logic wdt_enable,
    input wire logic [3:0] period_sel,
    input wire logic restart,
    // Reset out
    output logic wdt_rst
);

    logic [15:0] cnt_r;
    logic [15:0] limit;
    logic [3:0] sel_c;
    logic [1:0] hold_ticks_r;

    assign sel_c = (period_sel > `SRS_WDT_SEL_MAX) ? `SRS_WDT_SEL_MAX : period_sel;
    assign limit = `SRS_WDT_BASE << sel_c;

    always_ff @(posedge clk) begin
        if (srst || !wdt_enable || restart || wdt_rst) begin
            cnt_r <= 16'h0000;
        end else if (osc_tick) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // The pulse ends at the next oscillator edge, so it spans one oscillator period.
    always_ff @(posedge clk) begin
        if (srst) begin
            wdt_rst <= 1'b0;
        end else if (wdt_rst && osc_tick) begin
            wdt_rst <= 1'b0; // [R05]
        end else if (wdt_enable && !restart && osc_tick && cnt_r == limit - 16'h0001) begin
            wdt_rst <= 1'b1; // [R04]
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !wdt_rst) begin
            hold_ticks_r <= 2'h0;
        end else if (osc_tick && hold_ticks_r != 2'h3) begin
            hold_ticks_r <= hold_ticks_r + 2'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_wdt_timeout;
        wdt_enable && !restart && osc_tick && !wdt_rst && cnt_r == limit - 16'h0001 |=> wdt_rst;
    endproperty
    a_wdt_timeout: assert property (p_wdt_timeout) else $error("watchdog timeout missed"); // [R04]

    property p_wdt_width;
        hold_ticks_r <= 2'h1;
    endproperty
    a_wdt_width: assert property (p_wdt_width) else $error("watchdog reset too long"); // [R05]

    property p_wdt_restart;
        restart |=> !$rose(wdt_rst);
    endproperty
    a_wdt_restart: assert property (p_wdt_restart) else $error("reset after restart"); // [R04]

endmodule
`default_nettype wire

// ==== logic/srs_top.sv ====
// Purpose: Combines brownout, pin, watchdog, software and debug reset sources.
// Assumes: Comparator outputs, reset pin and oscillator are asynchronous.
// Notes: The combined reset is a registered level on the CPU clock.
`timescale 1ns/100ps
`default_nettype none
`include "srs_params.svh"

module srs_top (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Brownout comparators and fuses
    input wire logic [`SRS_BOD_LEVELS-1:0] supply_below,
    input wire logic [2:0] brownout_threshold_fuse,
    input wire logic brownout_fuse_enable,
    input wire logic chip_erase_active,
    // External reset pin
    input wire logic reset_pin_n,
    // Internal oscillator
    input wire logic osc_2mhz,
    // Watchdog control
    input wire logic wdt_enable,
    input wire logic [3:0] wdt_period_sel,
    input wire logic wdt_restart,
    // Software reset
    input wire logic sw_reset_wr,
    // Program and debug interface
    input wire logic program_debug_interface_en,
    input wire logic program_debug_interface_rst,
    // Cause flags
    input wire logic cause_clear,
    output srs_pkg::srs_src_s reset_cause,
    // Reset outputs
    output logic sys_rst,
    output logic cpu_halt
);

    localparam int NSYNC = `SRS_BOD_LEVELS + 4;

    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;
    logic [`SRS_BOD_LEVELS-1:0] below_s;
    logic pin_low_s;
    logic osc_s;
    logic dbg_en_s;
    logic dbg_rst_s;
    logic osc_d_r;
    logic osc_tick;

    srs_pkg::srs_src_s src;
    srs_pkg::srs_ext_e ext_state_r;
    logic [`SRS_TEXT_W-1:0] ext_cnt_r;
    logic bod_active;
    logic [2:0] bod_level;
    logic wdt_rst;
    logic sw_req_r;
    logic [2:0] sw_hold_r;
    logic sys_rst_r;
    srs_pkg::srs_src_s cause_r;

    assign async_in = {program_debug_interface_rst, program_debug_interface_en, osc_2mhz, ~reset_pin_n, supply_below};

    // Two flops on every asynchronous input before any logic reads it.
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (srst) begin
                    meta_r[gi] <= 1'b0;
                    sync_r[gi] <= 1'b0;
                end else begin
                    meta_r[gi] <= async_in[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    assign below_s = sync_r[`SRS_BOD_LEVELS-1:0];
    assign pin_low_s = sync_r[`SRS_BOD_LEVELS];
    assign osc_s = sync_r[`SRS_BOD_LEVELS+1];
    assign dbg_en_s = sync_r[`SRS_BOD_LEVELS+2];
    assign dbg_rst_s = sync_r[`SRS_BOD_LEVELS+3];

    always_ff @(posedge clk) begin
        if (srst) begin
            osc_d_r <= 1'b0;
        end else begin
            osc_d_r <= osc_s;
        end
    end

    assign osc_tick = osc_s && !osc_d_r;

    // Erase and debug keep brownout alive even when the fuse turns it off.
    assign bod_active = brownout_fuse_enable || chip_erase_active || dbg_en_s; // [R02]
    assign bod_level = brownout_fuse_enable ? brownout_threshold_fuse : `SRS_BOD_LOWEST; // [R02]
    assign src.brownout = bod_active && below_s[bod_level]; // [R01]

    // Short glitches on the pin are filtered by the qualification count.
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_state_r <= srs_pkg::EXT_IDLE;
            ext_cnt_r <= '0;
        end else begin
            case (ext_state_r)
                srs_pkg::EXT_IDLE: begin
                    ext_cnt_r <= '0;
                    if (pin_low_s) begin
                        ext_state_r <= srs_pkg::EXT_QUAL;
                    end
                end
                srs_pkg::EXT_QUAL: begin
                    if (!pin_low_s) begin
                        ext_state_r <= srs_pkg::EXT_IDLE;
                    end else if (ext_cnt_r == `SRS_TEXT_W'(`SRS_TEXT_CYC)) begin
                        ext_state_r <= srs_pkg::EXT_HOLD; // [R03]
                    end else begin
                        ext_cnt_r <= ext_cnt_r + `SRS_TEXT_W'(1);
                    end
                end
                srs_pkg::EXT_HOLD: begin
                    if (!pin_low_s) begin
                        ext_state_r <= srs_pkg::EXT_IDLE;
                    end
                end
                default: begin
                    ext_state_r <= srs_pkg::EXT_IDLE;
                end
            endcase
        end
    end

    assign src.ext_pin = (ext_state_r == srs_pkg::EXT_HOLD) && pin_low_s; // [R03]

    srs_wdt u_wdt (
        .clk(clk),
        .srst(srst),
        .osc_tick(osc_tick),
        .wdt_enable(wdt_enable),
        .period_sel(wdt_period_sel),
        .restart(wdt_restart),
        .wdt_rst(wdt_rst)
    );

    assign src.watchdog = wdt_rst; // [R04]

    // The request is held a few cycles so the combined reset sees it for sure.
    always_ff @(posedge clk) begin
        if (srst) begin
            sw_req_r <= 1'b0;
            sw_hold_r <= 3'h0;
        end else if (sw_reset_wr) begin
            sw_req_r <= 1'b1; // [R06]
            sw_hold_r <= 3'(`SRS_SW_HOLD_CYC);
        end else if (sw_hold_r != 3'h0) begin
            sw_hold_r <= sw_hold_r - 3'h1;
        end else begin
            sw_req_r <= 1'b0;
        end
    end

    assign src.software = sw_req_r; // [R07]
    assign cpu_halt = sw_reset_wr || sw_req_r; // [R08]

    // Only the debug pin input reaches this source; no core signal does.
    assign src.debug = dbg_rst_s; // [R09]

    always_ff @(posedge clk) begin
        if (srst) begin
            sys_rst_r <= 1'b1;
        end else begin
            sys_rst_r <= |src; // [R10]
        end
    end

    assign sys_rst = sys_rst_r;

    // A new cause wins over a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (srst) begin
            cause_r <= '0;
        end else begin
            cause_r <= (cause_clear ? '0 : cause_r) | src;
        end
    end

    assign reset_cause = cause_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_bod_trip;
        bod_active && below_s[bod_level] |=> sys_rst;
    endproperty
    a_bod_trip: assert property (p_bod_trip) else $error("brownout did not reset"); // [R01]

    property p_bod_forced;
        !brownout_fuse_enable && (chip_erase_active || dbg_en_s) |-> bod_active && bod_level == `SRS_BOD_LOWEST;
    endproperty
    a_bod_forced: assert property (p_bod_forced) else $error("brownout not forced low"); // [R02]

    property p_ext_hold;
        ext_state_r == srs_pkg::EXT_HOLD && pin_low_s |=> sys_rst;
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("pin reset not held"); // [R03]

    property p_ext_qual;
        $rose(src.ext_pin) |-> $past(ext_cnt_r) == `SRS_TEXT_W'(`SRS_TEXT_CYC);
    endproperty
    a_ext_qual: assert property (p_ext_qual) else $error("pin qualified early"); // [R03]

    property p_wdt_reset;
        wdt_rst |=> sys_rst;
    endproperty
    a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog not forwarded"); // [R04]

    property p_sw_start;
        sw_reset_wr |-> ##[1:2] sys_rst;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("software reset late"); // [R07]

    property p_sw_halt;
        sw_reset_wr |-> cpu_halt ##1 cpu_halt;
    endproperty
    a_sw_halt: assert property (p_sw_halt) else $error("core not halted"); // [R08]

    property p_dbg_only;
        $rose(src.debug) |-> $past(program_debug_interface_rst, 2);
    endproperty
    a_dbg_only: assert property (p_dbg_only) else $error("debug source mismatch"); // [R09]

    property p_release;
        !srst && !(|src) |=> !sys_rst;
    endproperty
    a_release: assert property (p_release) else $error("reset not released"); // [R10]

endmodule
`default_nettype wire

// ==== tb/srs_ext_party.sv ====
// Purpose: Model of the reset pin driver and the external debugger.
// Assumes: The pin has a pull-up, so a released pin reads high.
// Notes: Debug reset is raised only while the debugger is attached.
`timescale 1ns/100ps
`default_nettype none
module srs_ext_party (
    // Clock
    input wire logic clk,
    // Bench control
    input wire logic go,
    input wire logic [7:0] len,
    input wire logic dbg_on,
    input wire logic dbg_req,
    // Far side pins
    output logic reset_pin_n,
    output logic dbg_if_en,
    output logic dbg_if_rst
);
    logic [7:0] cnt_r = 8'h00;
    always @(posedge clk) begin
        if (go) begin
            cnt_r <= len;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
    assign reset_pin_n = (cnt_r == 8'h00);
    assign dbg_if_en = dbg_on;
    assign dbg_if_rst = dbg_on & dbg_req;
endmodule
`default_nettype wire

// ==== tb/system_reset_sources_bench.sv ====
// Purpose: Self-checking bench of the reset source block.
// Assumes: Oscillator of 2 MHz unrelated to the 125 MHz clock.
// Notes: Bounds allow for two-flop synchronisers on async inputs.
`timescale 1ns/100ps
`default_nettype none
`include "srs_params.svh"
module system_reset_sources_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [`SRS_BOD_LEVELS-1:0] below = 8'h00;
    logic [2:0] fuse = 3'h3;
    logic fuse_en = 1'b1;
    logic erase = 1'b0;
    logic osc = 1'b0;
    logic wdt_en = 1'b0;
    logic [3:0] wsel = 4'h0;
    logic wrst = 1'b0;
    logic sw_wr = 1'b0;
    logic cclr = 1'b0;
    logic go = 1'b0;
    logic [7:0] len = 8'h00;
    logic dbg_on = 1'b0;
    logic dbg_req = 1'b0;
    wire logic pin_n, dbg_if_en, dbg_if_rst, sys_rst, halt;
    srs_pkg::srs_src_s cause;
    int bad_count = 0;
    int num_checks = 0;
    int n;
    always #4 clk = ~clk;
    always #250 osc = ~osc;
    srs_ext_party party (.clk(clk), .go(go), .len(len), .dbg_on(dbg_on), .dbg_req(dbg_req),
        .reset_pin_n(pin_n), .dbg_if_en(dbg_if_en), .dbg_if_rst(dbg_if_rst));
    srs_top dut (.clk(clk), .srst(srst), .supply_below(below), .brownout_threshold_fuse(fuse),
        .brownout_fuse_enable(fuse_en), .chip_erase_active(erase), .reset_pin_n(pin_n), .osc_2mhz(osc),
        .wdt_enable(wdt_en), .wdt_period_sel(wsel), .wdt_restart(wrst), .sw_reset_wr(sw_wr),
        .program_debug_interface_en(dbg_if_en), .program_debug_interface_rst(dbg_if_rst),
        .cause_clear(cclr), .reset_cause(cause), .sys_rst(sys_rst), .cpu_halt(halt));
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk_cause(input logic [4:0] got, input logic [4:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_lvl(input logic got, input logic exp);
        chk_cause({4'h0, got}, {4'h0, exp});
    endtask
    // A wait that runs out of bound is a mismatch and ends the run.
    task automatic wait_rst(input logic v, input int lim, output int k);
        k = 0;
        while (sys_rst !== v) begin
            step(1);
            k++;
            if (k > lim) begin
                bad_count++;
                $display("mismatch t=%0t got=%h exp=%h", $time, sys_rst, v);
                end_sim();
            end
        end
        num_checks++;
    endtask
    task automatic hold_low(input int k);
        logic seen;
        seen = 1'b0;
        repeat (k) begin
            step(1);
            seen = seen | sys_rst;
        end
        chk_lvl(seen, 1'b0);
    endtask
    task automatic clr();
        @(posedge clk) cclr <= 1'b1;
        @(posedge clk) cclr <= 1'b0;
        step(1);
    endtask
    task automatic t_reset();
        #1 chk_lvl(sys_rst, 1'b1);
        wait_rst(1'b0, 3, n);
        chk_cause(cause, 5'h00);
        $display("test reset done");
    endtask
    task automatic t_brown();
        @(posedge clk) below <= 8'hF0;
        hold_low(10);
        @(posedge clk) below <= 8'hF8;
        wait_rst(1'b1, 6, n);
        chk_cause(cause, 5'h10);
        @(posedge clk) below <= 8'hF0;
        wait_rst(1'b0, 6, n);
        clr();
        @(posedge clk) fuse_en <= 1'b0;
        below <= 8'hF8;
        hold_low(10);
        @(posedge clk) erase <= 1'b1;
        hold_low(10);
        @(posedge clk) below <= 8'hFF;
        wait_rst(1'b1, 6, n);
        @(posedge clk) erase <= 1'b0;
        wait_rst(1'b0, 6, n);
        @(posedge clk) dbg_on <= 1'b1;
        wait_rst(1'b1, 6, n);
        @(posedge clk) dbg_on <= 1'b0;
        wait_rst(1'b0, 6, n);
        @(posedge clk) below <= 8'h00;
        repeat (3) @(posedge clk);
        fuse_en <= 1'b1;
        $display("test brownout done");
    endtask
    task automatic t_pin();
        clr();
        @(posedge clk) go <= 1'b1;
        len <= 8'h3C;
        @(posedge clk) go <= 1'b0;
        hold_low(100);
        @(posedge clk) go <= 1'b1;
        len <= 8'hC8;
        @(posedge clk) go <= 1'b0;
        wait_rst(1'b1, 150, n);
        chk_lvl(n >= `SRS_TEXT_CYC, 1'b1);
        wait_rst(1'b0, 100, n);
        chk_lvl(n >= 60, 1'b1);
        chk_cause(cause, 5'h08);
        $display("test pin done");
    endtask
    task automatic t_wdt();
        clr();
        @(posedge clk) wdt_en <= 1'b1;
        repeat (10) begin
            @(posedge clk) wrst <= 1'b1;
            @(posedge clk) wrst <= 1'b0;
            hold_low(200);
        end
        wait_rst(1'b1, 800, n);
        wait_rst(1'b0, 200, n);
        @(posedge clk) wdt_en <= 1'b0;
        chk_lvl(n >= 62 && n <= 126, 1'b1);
        chk_cause(cause, 5'h04);
        $display("test watchdog done");
    endtask
    task automatic t_sw();
        clr();
        @(posedge clk) sw_wr <= 1'b1;
        #1 chk_lvl(halt, 1'b1);
        @(posedge clk) sw_wr <= 1'b0;
        #1 chk_lvl(halt, 1'b1);
        wait_rst(1'b1, 2, n);
        chk_cause(cause, 5'h02);
        wait_rst(1'b0, 10, n);
        $display("test software done");
    endtask
    task automatic t_dbg();
        clr();
        @(posedge clk) dbg_on <= 1'b1;
        dbg_req <= 1'b1;
        wait_rst(1'b1, 6, n);
        chk_cause(cause, 5'h01);
        @(posedge clk) dbg_req <= 1'b0;
        wait_rst(1'b0, 6, n);
        $display("test debug done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_brown();
        t_pin();
        t_wdt();
        t_sw();
        t_dbg();
        end_sim();
    end
endmodule
`default_nettype wire
